/* hw/power_ctrl_pkg.sv */
// Constants, register map and types shared by the reset, clock and power control block.
package power_ctrl_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS   = 40;
  localparam int RC_PERIOD_NS    = 100000;
  localparam int RC_CYCLES       = (RC_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [11:0] RC_DIV_LAST = 12'(RC_CYCLES - 1);
  localparam int RC_HZ           = 10000;
  localparam int WDOG_TIMEOUT_S  = 2;
  localparam int WDOG_TICKS      = WDOG_TIMEOUT_S * RC_HZ;
  localparam logic [1:0]  PAD_RC_LAST  = 2'h2;
  localparam logic [10:0] CORE_RELEASE_LAST = 11'h3FF;
  localparam logic [10:0] CORE_RELEASE_EDGES = 11'h400;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CAUSE    = 8'h00;
  localparam logic [7:0] ADDR_CONTROL  = 8'h04;
  localparam logic [7:0] ADDR_POWER    = 8'h08;
  localparam logic [7:0] ADDR_TICK_DIV = 8'h0C;
  localparam logic [7:0] ADDR_PRESCALE = 8'h10;
  localparam logic [7:0] ADDR_TIMER    = 8'h14;
  localparam logic [7:0] ADDR_WAKE_CMP = 8'h18;
  localparam logic [7:0] ADDR_RANDOM   = 8'h1C;
  localparam logic [7:0] ADDR_STATUS   = 8'h20;

  localparam logic [7:0] TICK_DIV_RESET = 8'h0A;
  localparam logic [3:0] PRESCALE_RESET = 4'h0;
  localparam logic [15:0] WAKE_CMP_RESET = 16'h0000;

  localparam int CTRL_SW_RESET     = 0;
  localparam int CTRL_WDOG_RESTART = 1;

  localparam logic [4:0] CAUSE_POR  = 5'h01;
  localparam logic [4:0] CAUSE_WDOG = 5'h02;
  localparam logic [4:0] CAUSE_PC   = 5'h04;
  localparam logic [4:0] CAUSE_SW   = 5'h08;
  localparam logic [4:0] CAUSE_DIP  = 5'h10;

  localparam logic [1:0] REQ_IDLE = 2'h1;
  localparam logic [1:0] REQ_DEEP = 2'h2;
  localparam logic [1:0] REQ_DOWN = 2'h3;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // Pin inputs and modes
  // ----------------------------------------------------------------
  localparam int IN_PADS_OK = 0;
  localparam int IN_CORE_OK = 1;
  localparam int IN_DIP     = 2;
  localparam int IN_NOISE   = 3;
  localparam int IN_WAKE    = 4;
  localparam int IN_COUNT   = 5;
  localparam int PAD_WIDTH  = 8;

  typedef enum logic [4:0] {
    MODE_ACTIVE = 5'h01,
    MODE_IDLE   = 5'h02,
    MODE_DEEP   = 5'h04,
    MODE_DOWN   = 5'h08,
    MODE_WAKE   = 5'h10
  } power_mode_type;

endpackage

/* hw/pin_sync.sv */
// Three-stage synchroniser for asynchronous pin levels.
`timescale 1ns/1ns
module pin_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             sys_clk,
  input  wire logic             rst,
  // Levels
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] stable_out
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;

  // A change is passed on only once the second and third stages agree.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      stage1     <= '0;
      stage2     <= '0;
      stage3     <= '0;
      stable_out <= '0;
    end else begin
      stage1 <= async_in;
      stage2 <= stage1;
      stage3 <= stage2;
      for (int i = 0; i < WIDTH; i++) begin
        if (stage2[i] == stage3[i]) begin
          stable_out[i] <= stage3[i];
        end
      end
    end
  end

endmodule

/* hw/reset_clock_sleep_power_control.sv */
// Reset sequencing, reset cause, RC tick, sleep timer, watchdog and power modes.
`timescale 1ns/1ns
module reset_clock_sleep_power_control #(
  parameter int WDOG_TICKS = power_ctrl_pkg::WDOG_TICKS
) (
  // Clock and reset
  input  wire logic                                sys_clk,
  input  wire logic                                rst,
  // AXI4-Lite write channels
  input  wire logic                                awvalid,
  output logic                                     awready,
  input  wire logic [7:0]                          awaddr,
  input  wire logic [2:0]                          awprot,
  input  wire logic                                wvalid,
  output logic                                     wready,
  input  wire logic [31:0]                         wdata,
  input  wire logic [3:0]                          wstrb,
  output logic                                     bvalid,
  input  wire logic                                bready,
  output logic [1:0]                               bresp,
  // AXI4-Lite read channels
  input  wire logic                                arvalid,
  output logic                                     arready,
  input  wire logic [7:0]                          araddr,
  input  wire logic [2:0]                          arprot,
  output logic                                     rvalid,
  input  wire logic                                rready,
  output logic [31:0]                              rdata,
  output logic [1:0]                               rresp,
  // Analog and pin inputs
  input  wire logic                                pads_supply_ok,
  input  wire logic                                core_supply_ok,
  input  wire logic                                core_supply_dip,
  input  wire logic                                rx_noise_bit,
  input  wire logic                                wake_pin,
  // Core-side inputs
  input  wire logic                                irq_pending,
  input  wire logic                                pc_rollover,
  input  wire logic [power_ctrl_pkg::PAD_WIDTH-1:0] core_pad_out,
  // Reset and power controls
  output logic                                     pad_reset,
  output logic                                     core_reset,
  output logic                                     cpu_halt,
  output logic                                     core_power_enable,
  output logic                                     regulator_enable,
  output logic                                     regulator_output,
  output logic                                     pad_freeze,
  output logic [power_ctrl_pkg::PAD_WIDTH-1:0]     pad_out
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [power_ctrl_pkg::IN_COUNT-1:0] pins;

  pin_sync #(.WIDTH(power_ctrl_pkg::IN_COUNT)) u_pin_sync (
    .sys_clk    (sys_clk),
    .rst        (rst),
    .async_in   ({wake_pin, rx_noise_bit, core_supply_dip, core_supply_ok, pads_supply_ok}),
    .stable_out (pins)
  );

  wire pads_ok = pins[power_ctrl_pkg::IN_PADS_OK];
  wire core_ok = pins[power_ctrl_pkg::IN_CORE_OK];
  wire noise   = pins[power_ctrl_pkg::IN_NOISE];

  logic dip_d;
  logic wake_d;
  wire  dip_rise  = pins[power_ctrl_pkg::IN_DIP] && !dip_d;
  wire  wake_rise = pins[power_ctrl_pkg::IN_WAKE] && !wake_d;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      dip_d  <= 1'b0;
      wake_d <= 1'b0;
    end else begin
      dip_d  <= pins[power_ctrl_pkg::IN_DIP];
      wake_d <= pins[power_ctrl_pkg::IN_WAKE];
    end
  end

  // ----------------------------------------------------------------
  // Registers and bus decode
  // ----------------------------------------------------------------
  power_ctrl_pkg::power_mode_type mode;
  logic [4:0]  reset_cause;
  logic [7:0]  tick_div;
  logic [3:0]  prescale;
  logic [15:0] wake_cmp;
  logic [15:0] sleep_timer;
  logic        random_bit;
  logic        aw_held;
  logic        w_held;
  logic [7:0]  aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0]  w_strb_q;
  logic [31:0] read_mux;

  function automatic logic is_mapped(input logic [7:0] addr);
    return addr == power_ctrl_pkg::ADDR_CAUSE    || addr == power_ctrl_pkg::ADDR_CONTROL  ||
           addr == power_ctrl_pkg::ADDR_POWER    || addr == power_ctrl_pkg::ADDR_TICK_DIV ||
           addr == power_ctrl_pkg::ADDR_PRESCALE || addr == power_ctrl_pkg::ADDR_TIMER    ||
           addr == power_ctrl_pkg::ADDR_WAKE_CMP || addr == power_ctrl_pkg::ADDR_RANDOM   ||
           addr == power_ctrl_pkg::ADDR_STATUS;
  endfunction

  assign awready = !aw_held && !bvalid;
  assign wready  = !w_held && !bvalid;
  assign arready = !rvalid;

  wire write_go     = aw_held && w_held && !bvalid;
  wire wr_lane0     = write_go && w_strb_q[0];
  wire wr_control   = wr_lane0 && aw_addr_q == power_ctrl_pkg::ADDR_CONTROL;
  wire wr_power     = wr_lane0 && aw_addr_q == power_ctrl_pkg::ADDR_POWER;
  wire wr_tick_div  = wr_lane0 && aw_addr_q == power_ctrl_pkg::ADDR_TICK_DIV;
  wire wr_prescale  = wr_lane0 && aw_addr_q == power_ctrl_pkg::ADDR_PRESCALE;
  wire wr_wake_cmp  = write_go && aw_addr_q == power_ctrl_pkg::ADDR_WAKE_CMP;
  wire sw_reset_req = wr_control && w_data_q[power_ctrl_pkg::CTRL_SW_RESET];
  wire wdog_restart = wr_control && w_data_q[power_ctrl_pkg::CTRL_WDOG_RESTART];
  wire mode_write   = wr_power && mode == power_ctrl_pkg::MODE_ACTIVE;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      aw_held   <= 1'b0;
      w_held    <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q  <= 32'h00000000;
      w_strb_q  <= 4'h0;
      bvalid    <= 1'b0;
      bresp     <= power_ctrl_pkg::RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        aw_held   <= 1'b1;
        aw_addr_q <= awaddr;
      end
      if (wvalid && wready) begin
        w_held   <= 1'b1;
        w_data_q <= wdata;
        w_strb_q <= wstrb;
      end
      if (write_go) begin
        aw_held <= 1'b0;
        w_held  <= 1'b0;
        bvalid  <= 1'b1;
        bresp   <= is_mapped(aw_addr_q) ? power_ctrl_pkg::RESP_OKAY : power_ctrl_pkg::RESP_SLVERR;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  always_comb begin
    if (araddr == power_ctrl_pkg::ADDR_CAUSE) begin
      read_mux = {27'h0000000, reset_cause};
    end else if (araddr == power_ctrl_pkg::ADDR_TICK_DIV) begin
      read_mux = {24'h000000, tick_div};
    end else if (araddr == power_ctrl_pkg::ADDR_PRESCALE) begin
      read_mux = {28'h0000000, prescale};
    end else if (araddr == power_ctrl_pkg::ADDR_TIMER) begin
      read_mux = {16'h0000, sleep_timer};
    end else if (araddr == power_ctrl_pkg::ADDR_WAKE_CMP) begin
      read_mux = {16'h0000, wake_cmp};
    end else if (araddr == power_ctrl_pkg::ADDR_RANDOM) begin
      read_mux = {31'h00000000, random_bit};
    end else if (araddr == power_ctrl_pkg::ADDR_STATUS) begin
      read_mux = {25'h0000000, core_reset, pad_reset, mode};
    end else begin
      read_mux = 32'h00000000;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rvalid <= 1'b0;
      rdata  <= 32'h00000000;
      rresp  <= power_ctrl_pkg::RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rdata  <= read_mux;
      rresp  <= is_mapped(araddr) ? power_ctrl_pkg::RESP_OKAY : power_ctrl_pkg::RESP_SLVERR;
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      tick_div <= power_ctrl_pkg::TICK_DIV_RESET;
      prescale <= power_ctrl_pkg::PRESCALE_RESET;
      wake_cmp <= power_ctrl_pkg::WAKE_CMP_RESET;
    end else begin
      if (wr_tick_div) begin
        tick_div <= w_data_q[7:0];
      end
      if (wr_prescale) begin
        prescale <= w_data_q[3:0];
      end
      if (wr_wake_cmp && w_strb_q[0]) begin
        wake_cmp[7:0] <= w_data_q[7:0];
      end
      if (wr_wake_cmp && w_strb_q[1]) begin
        wake_cmp[15:8] <= w_data_q[15:8];
      end
    end
  end

  // ----------------------------------------------------------------
  // RC oscillator, calibrated tick and sleep timer
  // ----------------------------------------------------------------
  logic [11:0] rc_count;
  logic [7:0]  tick_count;
  logic [15:0] pre_count;
  wire         rc_tick   = rc_count == power_ctrl_pkg::RC_DIV_LAST;
  wire  [7:0]  tick_last = (tick_div == 8'h00) ? 8'h00 : 8'(tick_div - 8'h01);
  wire         khz_tick  = rc_tick && tick_count >= tick_last;
  wire  [15:0] pre_last  = 16'((16'h0001 << prescale) - 16'h0001);
  wire         ms_tick   = khz_tick && pre_count >= pre_last;
  wire  [15:0] timer_inc = 16'(sleep_timer + 16'h0001);
  wire         timer_hit = ms_tick && timer_inc == wake_cmp;

  // The RC divider has no enable: it keeps running in every power mode.
  always_ff @(posedge sys_clk) begin
    if (rst || rc_tick) begin
      rc_count <= 12'h000;
    end else begin
      rc_count <= 12'(rc_count + 12'h001);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      tick_count  <= 8'h00;
      pre_count   <= 16'h0000;
      sleep_timer <= 16'h0000;
      random_bit  <= 1'b0;
    end else begin
      if (rc_tick) begin
        tick_count <= khz_tick ? 8'h00 : 8'(tick_count + 8'h01);
        random_bit <= noise;
      end
      if (khz_tick) begin
        pre_count <= ms_tick ? 16'h0000 : 16'(pre_count + 16'h0001);
      end
      if (ms_tick) begin
        sleep_timer <= timer_inc;
      end
    end
  end

  // ----------------------------------------------------------------
  // Reset sequencing, watchdog and reset cause
  // ----------------------------------------------------------------
  logic [1:0]  rc_pulses;
  logic [10:0] release_count;
  logic [15:0] wdog_count;
  wire         sleeping    = mode == power_ctrl_pkg::MODE_DEEP || mode == power_ctrl_pkg::MODE_DOWN;
  wire         supply_good = !pad_reset && core_ok && !sleeping;
  wire         wdog_fire   = rc_tick && wdog_count == 16'(WDOG_TICKS - 1);
  wire         pc_event    = pc_rollover && !core_reset;
  wire         core_event  = wdog_fire || sw_reset_req || dip_rise || pc_event;

  always_ff @(posedge sys_clk) begin
    if (rst || !pads_ok) begin
      rc_pulses <= 2'h0;
      pad_reset <= 1'b1;
    end else if (rc_tick && pad_reset) begin
      rc_pulses <= 2'(rc_pulses + 2'h1);
      if (rc_pulses == power_ctrl_pkg::PAD_RC_LAST) begin
        pad_reset <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst || !supply_good || core_event) begin
      release_count <= 11'h000;
      core_reset    <= 1'b1;
    end else if (core_reset) begin
      release_count <= 11'(release_count + 11'h001);
      if (release_count == power_ctrl_pkg::CORE_RELEASE_LAST) begin
        core_reset <= 1'b0;
      end
    end
  end

  // The watchdog drives the core reset and returns the mode to MODE_ACTIVE; it never touches pad_reset.
  always_ff @(posedge sys_clk) begin
    if (rst || core_reset || wdog_restart || wdog_fire) begin
      wdog_count <= 16'h0000;
    end else if (rc_tick) begin
      wdog_count <= 16'(wdog_count + 16'h0001);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst || !pads_ok) begin
      reset_cause <= power_ctrl_pkg::CAUSE_POR;
    end else if (dip_rise) begin
      reset_cause <= power_ctrl_pkg::CAUSE_DIP;
    end else if (wdog_fire) begin
      reset_cause <= power_ctrl_pkg::CAUSE_WDOG;
    end else if (pc_event) begin
      reset_cause <= power_ctrl_pkg::CAUSE_PC;
    end else if (sw_reset_req) begin
      reset_cause <= power_ctrl_pkg::CAUSE_SW;
    end
  end

  // ----------------------------------------------------------------
  // Power modes
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst || pad_reset || wdog_fire) begin
      mode <= power_ctrl_pkg::MODE_ACTIVE;
    end else begin
      case (mode)
        power_ctrl_pkg::MODE_ACTIVE: begin
          if (mode_write && w_data_q[1:0] == power_ctrl_pkg::REQ_IDLE) begin
            mode <= power_ctrl_pkg::MODE_IDLE;
          end else if (mode_write && w_data_q[1:0] == power_ctrl_pkg::REQ_DEEP) begin
            mode <= power_ctrl_pkg::MODE_DEEP;
          end else if (mode_write && w_data_q[1:0] == power_ctrl_pkg::REQ_DOWN) begin
            mode <= power_ctrl_pkg::MODE_DOWN;
          end
        end
        power_ctrl_pkg::MODE_IDLE: begin
          if (irq_pending) begin
            mode <= power_ctrl_pkg::MODE_ACTIVE;
          end
        end
        power_ctrl_pkg::MODE_DEEP: begin
          if (timer_hit || wake_rise) begin
            mode <= power_ctrl_pkg::MODE_WAKE;
          end
        end
        power_ctrl_pkg::MODE_DOWN: begin
          if (wake_rise) begin
            mode <= power_ctrl_pkg::MODE_WAKE;
          end
        end
        power_ctrl_pkg::MODE_WAKE: begin
          if (!core_reset) begin
            mode <= power_ctrl_pkg::MODE_ACTIVE;
          end
        end
        default: begin
          mode <= power_ctrl_pkg::MODE_ACTIVE;
        end
      endcase
    end
  end

  assign cpu_halt          = mode == power_ctrl_pkg::MODE_IDLE;
  assign core_power_enable = !sleeping;
  assign regulator_enable  = !sleeping;
  assign regulator_output  = !sleeping;
  assign pad_freeze        = sleeping || mode == power_ctrl_pkg::MODE_WAKE;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pad_out <= '0;
    end else if (!pad_freeze) begin
      pad_out <= core_pad_out;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  logic [10:0] good_run;
  always_ff @(posedge sys_clk) begin
    if (rst || !supply_good || core_event) begin
      good_run <= 11'h000;
    end else if (good_run != 11'h7FF) begin
      good_run <= 11'(good_run + 11'h001);
    end
  end

  sequence sleep_exit_seq;
    sleeping ##1 mode == power_ctrl_pkg::MODE_WAKE;
  endsequence

  chk_cause_watchdog: assert property (pads_ok && wdog_fire && !dip_rise |=> reset_cause == power_ctrl_pkg::CAUSE_WDOG) else $error("watchdog cause not logged");
  chk_pad_release: assert property ($fell(pad_reset) |-> $past(rc_tick) && $past(pads_ok)) else $error("pad reset released early");
  chk_core_supply_hold: assert property (!core_ok |=> core_reset) else $error("core out of reset with supply low");
  chk_core_release_count: assert property ($fell(core_reset) |-> good_run >= power_ctrl_pkg::CORE_RELEASE_EDGES) else $error("core released before edge count");
  chk_rc_runs_asleep: assert property (sleeping && !rc_tick |=> rc_count == 12'($past(rc_count) + 12'h001)) else $error("rc divider stalled in sleep");
  chk_timer_wrap: assert property (ms_tick |=> sleep_timer == 16'($past(sleep_timer) + 16'h0001)) else $error("sleep timer did not step");
  chk_timer_steady: assert property (!ms_tick |=> $stable(sleep_timer)) else $error("sleep timer moved without tick");
  chk_noise_sample: assert property (rc_tick |=> random_bit == $past(noise)) else $error("noise bit not sampled");
  chk_watchdog_reset: assert property (wdog_fire |=> core_reset && mode == power_ctrl_pkg::MODE_ACTIVE) else $error("watchdog did not reset");
  chk_idle_resume: assert property (mode == power_ctrl_pkg::MODE_IDLE && irq_pending |=> !cpu_halt) else $error("idle did not resume on interrupt");
  chk_sleep_core_reset: assert property ($rose(sleeping) |-> !regulator_output ##1 core_reset) else $error("sleep left core powered");
  chk_pads_frozen: assert property (pad_freeze |=> $stable(pad_out)) else $error("pads moved while frozen");
  chk_wake_regulator: assert property (sleep_exit_seq |-> regulator_enable && core_reset) else $error("wake without regulator");
  chk_down_no_timer: assert property (mode == power_ctrl_pkg::MODE_DOWN && !wake_rise && !pad_reset |=> mode == power_ctrl_pkg::MODE_DOWN) else $error("power down left without pin");
  chk_cause_hold: assert property (!core_event && pads_ok |=> $stable(reset_cause)) else $error("reset cause changed without reset");

endmodule

/* verif/supply_model.sv */
// Model of the supplies, noise source and wake line around the block.
`timescale 1ns/1ns
module supply_model (
  // Clock and request
  input  wire logic sys_clk,
  input  wire logic wake_req,
  input  wire logic dip_req,
  // Lines toward the block
  output logic      pads_supply_ok,
  output logic      core_supply_ok,
  output logic      core_supply_dip,
  output logic      rx_noise_bit,
  output logic      wake_pin
);
  // Pad supply comes up first, the regulator output a little later.
  initial begin
    {pads_supply_ok, core_supply_ok} = 2'h0;
    repeat (4) @(posedge sys_clk);
    pads_supply_ok <= 1'h1;
    repeat (4) @(posedge sys_clk);
    core_supply_ok <= 1'h1;
  end
  always @(posedge sys_clk) begin
    rx_noise_bit <= 1'($urandom);
    wake_pin <= wake_req;
    core_supply_dip <= dip_req;
  end
endmodule

/* verif/testbench.sv */
// Self-checking bench for the reset, clock and power control block.
`timescale 1ns/1ns
module testbench;
  logic sys_clk, rst, awvalid, wvalid, bready, arvalid, rready, irq_pending, pc_rollover;
  logic awready, wready, bvalid, arready, rvalid, pad_reset, core_reset, cpu_halt, wake_req;
  logic core_power_enable, regulator_enable, regulator_output, pad_freeze, dip_req;
  logic pads_supply_ok, core_supply_ok, core_supply_dip, rx_noise_bit, wake_pin;
  logic [7:0] awaddr, araddr, core_pad_out, pad_out, v;
  logic [31:0] wdata, rdata, t;
  logic [2:0] awprot, arprot;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic [33:0] exp_q[$];
  int miscompares, n_compared, n;
  reset_clock_sleep_power_control #(.WDOG_TICKS(4)) i_reset_clock_sleep_power_control (.*);
  supply_model i_supply_model (.*);
  initial begin
    sys_clk = 1'h0;
    forever #20 sys_clk = ~sys_clk;
  end
  task chk(input logic [33:0] g, input logic [33:0] e);
    n_compared++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %0t got %h exp %h", $time, g, e);
    end
  endtask
  task cyc(input int k);
    repeat (k) @(posedge sys_clk);
  endtask
  task automatic wt(ref logic s, input logic l, output int c);
    c = 0;
    while (s !== l) begin
      @(posedge sys_clk);
      c++;
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    awaddr <= a; wdata <= d; awvalid <= 1'h1; wvalid <= 1'h1; bready <= 1'h1;
    do begin
      @(posedge sys_clk);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
    end while (awvalid || wvalid);
    do @(posedge sys_clk); while (bvalid !== 1'h1);
  endtask
  task rd(input logic [7:0] a, input logic [33:0] e);
    exp_q.push_back(e);
    araddr <= a; arvalid <= 1'h1; rready <= 1'h1;
    do @(posedge sys_clk); while (arready !== 1'h1);
    arvalid <= 1'h0;
    do @(posedge sys_clk); while (rvalid !== 1'h1);
  endtask
  // Reads a value for use as stimulus; it leaves no note, so the watcher skips it.
  task rdv(input logic [7:0] a, output logic [31:0] d);
    araddr <= a; arvalid <= 1'h1; rready <= 1'h1;
    do @(posedge sys_clk); while (arready !== 1'h1);
    arvalid <= 1'h0;
    do @(posedge sys_clk); while (rvalid !== 1'h1);
    d = rdata;
  endtask
  always @(posedge sys_clk)
    if (rvalid === 1'h1 && rready === 1'h1 && exp_q.size() > 0) chk({rresp, rdata}, exp_q.pop_front());
  task close_out;
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    void'($urandom(97));
    {rst, wstrb} = 5'h1F;
    {awvalid, wvalid, bready, arvalid, rready, wake_req, irq_pending, pc_rollover, dip_req} = 9'h000;
    {awaddr, araddr, wdata, awprot, arprot, core_pad_out} = 62'h0;
    cyc(8);
    rst <= 1'h0;
    wt(pad_reset, 1'h0, n);
    chk(n >= 5000, 1'h1);
    wt(core_reset, 1'h0, n);
    chk(n inside {[1024:1030]}, 1'h1);
    $display("power-up done");
    rd(8'h00, 34'h1);
    rd(8'h0C, 34'hA);
    rd(8'h20, 34'h1);
    rd(8'h24, 34'h200000000);
    v = 8'($urandom_range(255, 1));
    wr(8'h0C, {24'h0, v});
    rd(8'h0C, {26'h0, v});
    $display("registers done");
    wr(8'h08, 32'h1);
    cyc(2);
    chk({cpu_halt, core_power_enable}, 2'h3);
    irq_pending <= 1'h1;
    cyc(3);
    chk(cpu_halt, 1'h0);
    irq_pending <= 1'h0;
    v = 8'($urandom);
    core_pad_out <= v;
    cyc(2);
    wr(8'h08, 32'h2);
    cyc(2);
    chk({regulator_output, regulator_enable, core_power_enable, pad_freeze}, 4'h1);
    core_pad_out <= ~v;
    cyc(5);
    chk(pad_out, v);
    rd(8'h20, 34'h44);
    wake_req <= 1'h1;
    cyc(10);
    chk(regulator_enable, 1'h1);
    wake_req <= 1'h0;
    wt(core_reset, 1'h0, n);
    rd(8'h20, 34'h1);
    rd(8'h00, 34'h1);
    wr(8'h0C, 32'h1);
    wr(8'h10, 32'h1);
    rdv(8'h14, t);
    wr(8'h18, {16'h0, 16'(t[15:0] + 16'h2)});
    wr(8'h08, 32'h2);
    cyc(2);
    wt(core_reset, 1'h0, n);
    chk(n inside {[5900:11100]}, 1'h1);
    rd(8'h20, 34'h1);
    rdv(8'h14, t);
    wr(8'h18, {16'h0, 16'(t[15:0] + 16'h1)});
    wr(8'h08, 32'h3);
    cyc(12000);
    rd(8'h20, 34'h48);
    wake_req <= 1'h1;
    cyc(10);
    chk(regulator_enable, 1'h1);
    wake_req <= 1'h0;
    wt(core_reset, 1'h0, n);
    rd(8'h20, 34'h1);
    $display("sleep done");
    wr(8'h04, 32'h1);
    cyc(2);
    chk(core_reset, 1'h1);
    wt(core_reset, 1'h0, n);
    rd(8'h00, 34'h8);
    pc_rollover <= 1'h1;
    cyc(1);
    pc_rollover <= 1'h0;
    cyc(1);
    chk(core_reset, 1'h1);
    wt(core_reset, 1'h0, n);
    rd(8'h00, 34'h4);
    dip_req <= 1'h1;
    cyc(8);
    dip_req <= 1'h0;
    chk(core_reset, 1'h1);
    wt(core_reset, 1'h0, n);
    rd(8'h00, 34'h10);
    repeat (3) begin
      cyc(6000);
      wr(8'h04, 32'h2);
    end
    chk(core_reset, 1'h0);
    wt(core_reset, 1'h1, n);
    chk(n inside {[7400:12600]}, 1'h1);
    wt(core_reset, 1'h0, n);
    rd(8'h00, 34'h2);
    $display("resets done");
    close_out;
  end
  initial begin
    cyc(80000);
    miscompares++;
    close_out;
  end
endmodule
